// ===== include/dssw_defs.svh
// Timing, encoding and width constants of the supply supervisor
`ifndef DSSW_DEFS_SVH
`define DSSW_DEFS_SVH

// Clock rate and the base tick that all long timeouts count in
`define DSSW_CLK_KHZ        20000
`define DSSW_TICK_MS        1
`define DSSW_TICK_CYC       (`DSSW_TICK_MS * `DSSW_CLK_KHZ)
`define DSSW_TICK_W         15

// Reset hold choices in milliseconds
`define DSSW_HOLD_T0_MS     11'd50
`define DSSW_HOLD_T1_MS     11'd200
`define DSSW_HOLD_T2_MS     11'd400
`define DSSW_HOLD_T3_MS     11'd800

// Watchdog interval choices in milliseconds
`define DSSW_WDT_T0_MS      11'd25
`define DSSW_WDT_T1_MS      11'd200
`define DSSW_WDT_T2_MS      11'd1400

// Manual reset input must be stable this long before it is believed
`define DSSW_DEBOUNCE_MS    11'd10

// Millisecond counter width and its zero and one
`define DSSW_MS_W           11
`define DSSW_MS_ZERO        11'h000
`define DSSW_MS_ONE         11'h001

// Select encodings
`define DSSW_SEL_0          2'h0
`define DSSW_SEL_1          2'h1
`define DSSW_SEL_2          2'h2
`define DSSW_SEL_OFF        2'h3

// Reset value of the interval select before the stored value is loaded
`define DSSW_WDT_SEL_RST    2'h3

`endif

// ===== include/dssw_pkg.sv
// Types shared by the supply supervisor modules
package dssw_pkg;

    // Pin inputs after synchronisation, carried together
    typedef struct packed {
        logic primary_low;
        logic supply2_low;
        logic below_batt;
        logic mr_n;
        logic scl;
        logic sda;
    } dssw_pins_s;

    typedef enum logic [1:0] {
        DSSW_RST_ACTIVE,
        DSSW_RST_HOLD,
        DSSW_RST_IDLE
    } dssw_rst_e;

    typedef enum logic [1:0] {
        DSSW_KICK_IDLE,
        DSSW_KICK_STARTED,
        DSSW_KICK_CLOCKED
    } dssw_kick_e;

endpackage

// ===== rtl/dssw_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module dssw_sync #(
    parameter int          W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= RST_VAL;
            dout   <= RST_VAL;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule // dssw_sync

// ===== rtl/dssw_top.sv
// Supply supervisor: system reset, watchdog, supply flags and backup switch
`timescale 1ns/10ps
`include "dssw_defs.svh"
module dssw_top
    import dssw_pkg::*;
#(
    parameter bit RST_ACTIVE_HIGH = 1'b1,
    parameter int TICK_CYC        = `DSSW_TICK_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       primary_low,
    input  wire logic       supply2_low,
    input  wire logic       primary_below_batt,
    input  wire logic       manual_reset_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic [1:0] hold_sel,
    input  wire logic [1:0] wdt_sel_nv,
    input  wire logic       wdt_sel_wr,
    input  wire logic [1:0] wdt_sel_wdata,
    output logic            system_reset_out,
    output logic            watchdog_out_n_o,
    output logic            watchdog_out_n_oe,
    output logic            early_low_supply_n_o,
    output logic            early_low_supply_n_oe,
    output logic            supply2_fail_n_o,
    output logic            supply2_fail_n_oe,
    output logic            backup_source_active,
    output logic [1:0]      wdt_sel_store
);
    localparam logic [`DSSW_TICK_W-1:0] TICK_LAST = `DSSW_TICK_W'(TICK_CYC - 1);
    // Manual reset and both serial lines idle high, so no false edge follows reset
    localparam logic [5:0]              PIN_RST   = 6'h07;

    // Synchronised pins
    logic [5:0]  pins_raw;
    logic [5:0]  pins_vec;
    dssw_pins_s  pins;

    assign pins_raw = {primary_low, supply2_low, primary_below_batt,
                       manual_reset_n, scl_in, sda_in};

    dssw_sync #(
        .W       (6),
        .RST_VAL (PIN_RST)
    ) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (pins_raw),
        .dout (pins_vec)
    );

    assign pins = dssw_pins_s'(pins_vec);

    // Millisecond tick divider
    logic [`DSSW_TICK_W-1:0] tick_cnt_q;
    logic                    tick_q;
    wire                     tick_wrap = (tick_cnt_q == TICK_LAST);

    always_ff @(posedge clk) begin
        if (rst || tick_wrap) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + `DSSW_TICK_W'(1);
        end
        tick_q <= !rst && tick_wrap;
    end

    // Settings caught on the first cycle after power-on release
    logic       cfg_load_q;
    logic [1:0] hold_sel_q;
    logic [1:0] wdt_sel_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_load_q <= 1'b1;
            hold_sel_q <= `DSSW_SEL_0;
            wdt_sel_q  <= `DSSW_WDT_SEL_RST;
        end else begin
            cfg_load_q <= 1'b0;
            if (cfg_load_q) begin
                hold_sel_q <= hold_sel;
                wdt_sel_q  <= wdt_sel_nv;
            end else if (wdt_sel_wr) begin
                wdt_sel_q  <= wdt_sel_wdata;
            end
        end
    end

    // Lookup of the selected times in milliseconds
    wire [`DSSW_MS_W-1:0] hold_ms =
        (hold_sel_q == `DSSW_SEL_0) ? `DSSW_HOLD_T0_MS :
        (hold_sel_q == `DSSW_SEL_1) ? `DSSW_HOLD_T1_MS :
        (hold_sel_q == `DSSW_SEL_2) ? `DSSW_HOLD_T2_MS :
                                      `DSSW_HOLD_T3_MS;
    wire [`DSSW_MS_W-1:0] wdt_ms =
        (wdt_sel_q == `DSSW_SEL_0) ? `DSSW_WDT_T0_MS :
        (wdt_sel_q == `DSSW_SEL_1) ? `DSSW_WDT_T1_MS :
                                     `DSSW_WDT_T2_MS;
    wire wdt_enabled = (wdt_sel_q != `DSSW_SEL_OFF);

    // Manual reset debounce: the input must sit still for the debounce time
    logic                 mr_last_q;
    logic                 mr_db_n_q;
    logic [`DSSW_MS_W-1:0] db_cnt_q;
    wire                  mr_moved  = (pins.mr_n != mr_last_q);
    wire                  db_done   = (db_cnt_q >= `DSSW_DEBOUNCE_MS);

    always_ff @(posedge clk) begin
        if (rst) begin
            mr_last_q <= 1'b1;
            mr_db_n_q <= 1'b1;
            db_cnt_q  <= `DSSW_MS_ZERO;
        end else begin
            mr_last_q <= pins.mr_n;
            if (mr_moved) begin
                db_cnt_q <= `DSSW_MS_ZERO;
            end else if (db_done) begin
                mr_db_n_q <= mr_last_q;
            end else if (tick_q) begin
                db_cnt_q <= db_cnt_q + `DSSW_MS_ONE;
            end
        end
    end

    // Reset sequencer; one extra tick covers the free-running tick phase, never a short hold
    dssw_rst_e            rst_st_q;
    dssw_rst_e            rst_st_d;
    logic [`DSSW_MS_W-1:0] hold_cnt_q;
    wire                  rst_cause = pins.primary_low || !mr_db_n_q;
    wire                  hold_done = (hold_cnt_q > hold_ms);

    always_comb begin
        rst_st_d = rst_st_q;
        case (rst_st_q)
            DSSW_RST_ACTIVE: begin
                if (!rst_cause) begin
                    rst_st_d = DSSW_RST_HOLD;
                end
            end
            DSSW_RST_HOLD: begin
                if (rst_cause) begin
                    rst_st_d = DSSW_RST_ACTIVE;
                end else if (hold_done) begin
                    rst_st_d = DSSW_RST_IDLE;
                end
            end
            DSSW_RST_IDLE: begin
                if (rst_cause) begin
                    rst_st_d = DSSW_RST_ACTIVE;
                end
            end
            default: begin
                rst_st_d = DSSW_RST_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rst_st_q <= DSSW_RST_ACTIVE;
        end else begin
            rst_st_q <= rst_st_d;
        end
    end

    // Hold time restarts from zero whenever a cause is present
    always_ff @(posedge clk) begin
        if (rst || rst_st_q != DSSW_RST_HOLD) begin
            hold_cnt_q <= `DSSW_MS_ZERO;
        end else if (tick_q && !hold_done) begin
            hold_cnt_q <= hold_cnt_q + `DSSW_MS_ONE;
        end
    end

    wire sys_rst_on = (rst_st_d != DSSW_RST_IDLE);

    // Watchdog restart detection on the serial lines
    dssw_kick_e kick_st_q;
    dssw_kick_e kick_st_d;
    logic       scl_last_q;
    logic       sda_last_q;
    wire        sda_fall = sda_last_q && !pins.sda;
    wire        sda_rise = !sda_last_q && pins.sda;
    wire        scl_fall = scl_last_q && !pins.scl;
    wire        bus_stop = sda_rise && pins.scl && scl_last_q;
    wire        kick     = (kick_st_q == DSSW_KICK_CLOCKED) && bus_stop;

    always_comb begin
        kick_st_d = kick_st_q;
        case (kick_st_q)
            DSSW_KICK_IDLE: begin
                if (sda_fall) begin
                    kick_st_d = DSSW_KICK_STARTED;
                end
            end
            DSSW_KICK_STARTED: begin
                if (scl_fall) begin
                    kick_st_d = DSSW_KICK_CLOCKED;
                end
            end
            DSSW_KICK_CLOCKED: begin
                if (bus_stop) begin
                    kick_st_d = DSSW_KICK_IDLE;
                end
            end
            default: begin
                kick_st_d = DSSW_KICK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            kick_st_q  <= DSSW_KICK_IDLE;
            scl_last_q <= 1'b1;
            sda_last_q <= 1'b1;
        end else begin
            kick_st_q  <= kick_st_d;
            scl_last_q <= pins.scl;
            sda_last_q <= pins.sda;
        end
    end

    // Watchdog counter; idle while disabled or while the host is held in reset
    // Counting one tick past the interval keeps a timeout from firing early
    logic [`DSSW_MS_W-1:0] wdt_cnt_q;
    logic                 wdt_fired_q;
    wire                  wdt_hold  = !wdt_enabled || sys_rst_on;
    wire                  wdt_limit = (wdt_cnt_q > wdt_ms);

    always_ff @(posedge clk) begin
        if (rst || wdt_hold || kick) begin
            wdt_cnt_q <= `DSSW_MS_ZERO;
        end else if (tick_q && !wdt_limit) begin
            wdt_cnt_q <= wdt_cnt_q + `DSSW_MS_ONE;
        end
    end

    // Timeout stays active until the next restart, until the host is held in reset, or until the watchdog is switched off
    always_ff @(posedge clk) begin
        if (rst || wdt_hold || kick) begin
            wdt_fired_q <= 1'b0;
        end else if (wdt_limit) begin
            wdt_fired_q <= 1'b1;
        end
    end

    // Registered pin drivers; open-drain data bits are always low
    always_ff @(posedge clk) begin
        if (rst) begin
            system_reset_out      <= RST_ACTIVE_HIGH;
            watchdog_out_n_oe     <= 1'b0;
            early_low_supply_n_oe <= 1'b0;
            supply2_fail_n_oe     <= 1'b0;
            backup_source_active  <= 1'b0;
        end else begin
            system_reset_out      <= sys_rst_on ~^ RST_ACTIVE_HIGH;
            watchdog_out_n_oe     <= wdt_fired_q && wdt_enabled;
            early_low_supply_n_oe <= pins.primary_low;
            supply2_fail_n_oe     <= pins.supply2_low;
            backup_source_active  <= pins.primary_low && pins.below_batt;
        end
        watchdog_out_n_o     <= 1'b0;
        early_low_supply_n_o <= 1'b0;
        supply2_fail_n_o     <= 1'b0;
    end

    // Value presented to the nonvolatile cell for storage
    always_ff @(posedge clk) begin
        if (rst) begin
            wdt_sel_store <= `DSSW_WDT_SEL_RST;
        end else begin
            wdt_sel_store <= wdt_sel_q;
        end
    end
endmodule // dssw_top

// ===== verification/dssw_monitor.sv
// Port checker of the supply supervisor
`timescale 1ns/10ps
module dssw_monitor #(
    parameter bit RST_ACTIVE_HIGH = 1'b1,
    parameter int TICK_CYC        = 20000
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       primary_low,
    input wire logic       supply2_low,
    input wire logic       primary_below_batt,
    input wire logic       manual_reset_n,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       wdt_sel_wr,
    input wire logic [1:0] wdt_sel_wdata,
    input wire logic       system_reset_out,
    input wire logic       watchdog_out_n_oe,
    input wire logic       early_low_supply_n_oe,
    input wire logic       supply2_fail_n_oe,
    input wire logic       backup_source_active,
    input wire logic [1:0] wdt_sel_store
);
    localparam int HOLD_MIN = 50 * TICK_CYC;
    localparam int WDT_MIN  = 25 * TICK_CYC;
    localparam int WDT_LATE = 27 * TICK_CYC + 8;
    logic [2:0]  up_q;
    logic [31:0] calm_q;
    logic [31:0] idle_q;
    logic        sda_q;
    wire         rst_on = system_reset_out == RST_ACTIVE_HIGH;
    wire         stop   = sda_in && !sda_q && scl_in;
    wire         up     = up_q == 3'h4;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Quiet time since the last cause bounds every hold from below
    always_ff @(posedge clk) begin
        sda_q  <= sda_in;
        up_q   <= rst ? 3'h0 : (up ? up_q : up_q + 3'h1);
        calm_q <= (rst || primary_low || !manual_reset_n) ? 32'h0 : calm_q + 32'h1;
        idle_q <= (rst || stop || rst_on) ? 32'h0 : idle_q + 32'h1;
    end
    sequence s_reset_run;
        rst_on [*4];
    endsequence
    sequence s_wdt_off;
        (wdt_sel_store == 2'h3) [*4];
    endsequence
    a_low_flag:
    assert property (up |-> early_low_supply_n_oe == $past(primary_low, 3)) else $error("low flag");
    a_fail_flag:
    assert property (up |-> supply2_fail_n_oe == $past(supply2_low, 3)) else $error("fail flag");
    a_backup_select:
    assert property (up |-> backup_source_active == $past(primary_low && primary_below_batt, 3))
        else $error("backup flag");
    a_low_resets:
    assert property (up && $past(primary_low, 3) |-> rst_on) else $error("no low reset");
    a_hold_time:
    assert property ($changed(system_reset_out) && !rst_on |-> calm_q >= HOLD_MIN)
        else $error("early release");
    a_wdt_gap:
    assert property ($rose(watchdog_out_n_oe) |-> idle_q >= WDT_MIN) else $error("early wdt");
    a_wdt_fires:
    assert property (wdt_sel_store == 2'h0 && idle_q == WDT_LATE |-> watchdog_out_n_oe)
        else $error("late wdt");
    a_wdt_rst_quiet:
    assert property (s_reset_run |-> !watchdog_out_n_oe) else $error("wdt in reset");
    a_wdt_off_quiet:
    assert property (s_wdt_off |-> !watchdog_out_n_oe) else $error("wdt while off");
    a_sel_write:
    assert property (up && wdt_sel_wr |-> ##2 wdt_sel_store == $past(wdt_sel_wdata, 2))
        else $error("select store");
endmodule // dssw_monitor

// ===== verification/dssw_host_model.sv
// Host model that restarts the watchdog over the serial lines
`timescale 1ns/10ps
module dssw_host_model (
    input  wire logic       clk,
    input  wire logic       kick,
    input  wire logic [3:0] gap,
    output logic            scl,
    output logic            sda,
    output logic            busy
);
    initial begin
        scl  = 1'b1;
        sda  = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (kick) begin
                busy = 1'b1;
                // Each level stands at least one cycle so the synchroniser sees it
                @(negedge clk) sda = 1'b0;
                repeat (gap + 1) @(negedge clk);
                scl = 1'b0;
                repeat (gap + 1) @(negedge clk);
                scl = 1'b1;
                repeat (gap + 1) @(negedge clk);
                sda = 1'b1;
                busy = 1'b0;
            end
        end
    end
endmodule // dssw_host_model

// ===== verification/dssw_top_tb.sv
// Self-checking bench of the supply supervisor
`timescale 1ns/10ps
module dssw_top_tb;
    localparam int T = 10;
    int          ho[4] = '{50, 200, 400, 800};
    int          wdm[3] = '{25, 200, 1400};
    logic        clk = 1'b0, rst = 1'b1, pl = 1'b0, s2 = 1'b0, pb = 1'b0;
    logic        mr_n = 1'b1, kick = 1'b0, wr = 1'b0, hit;
    logic [1:0]  hs = 2'h0, nv = 2'h0, wd = 2'h0, st;
    logic        ro, wo, woe, eo, eoe, fo, foe, bk, scl, sda, busy;
    logic [2:0]  e;
    logic [2:0]  q[$];
    logic [15:0] lf = 16'h0063;
    int          err_total = 0, checked = 0, n;
    wire         wdo_n = woe ? wo : 1'b1;
    dssw_top #(.TICK_CYC(T)) uut (
        .clk(clk), .rst(rst), .primary_low(pl), .supply2_low(s2), .primary_below_batt(pb),
        .manual_reset_n(mr_n), .scl_in(scl), .sda_in(sda), .hold_sel(hs), .wdt_sel_nv(nv),
        .wdt_sel_wr(wr), .wdt_sel_wdata(wd), .system_reset_out(ro), .watchdog_out_n_o(wo),
        .watchdog_out_n_oe(woe), .early_low_supply_n_o(eo), .early_low_supply_n_oe(eoe),
        .supply2_fail_n_o(fo), .supply2_fail_n_oe(foe), .backup_source_active(bk),
        .wdt_sel_store(st));
    dssw_host_model host (.clk(clk), .kick(kick), .gap({2'h0, lf[5:4]}), .scl(scl),
        .sda(sda), .busy(busy));
    initial forever #25 clk = ~clk;
    function automatic logic [15:0] nx(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic await(logic k, logic lvl, int lim);
        n = 0;
        while ((k ? woe : ro) !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (n >= lim) begin
            err_total++;
            results();
        end
    endtask
    task automatic kick_host();
        kick = 1'b1;
        @(negedge clk);
        kick = 1'b0;
        for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk);
        chk("host", busy, 1'b0);
    endtask
    task automatic write_sel(logic [1:0] s);
        wr = 1'b1;
        wd = s;
        @(negedge clk);
        wr = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    initial begin
        for (int h = 3; h >= 0; h--) begin
            rst = 1'b1;
            hs = h[1:0];
            nv = lf[1:0];
            lf = nx(lf);
            repeat (16) @(negedge clk);
            chk("por", ro, 1'b1);
            rst = 1'b0;
            await(1'b0, 1'b0, 900 * T);
            chk("hold", n >= ho[h] * T && n <= (ho[h] + 2) * T + 8, 1'b1);
            chk("nv", st, nv);
        end
        repeat (400) begin
            @(negedge clk);
            if (q.size() == 3) begin
                e = q.pop_front();
                chk("low", eoe, e[0]);
                chk("s2fail", foe, e[1]);
                chk("backup", bk, e[2]);
                chk("drain", {wo, eo, fo}, 3'h0);
                if (e[0]) chk("lowrst", ro, 1'b1);
            end
            lf = nx(lf);
            pl = lf[0] & lf[3];
            s2 = lf[1];
            pb = lf[2];
            q.push_back({pl & pb, s2, pl});
        end
        @(negedge clk) pl = 1'b1;
        repeat (4) @(negedge clk);
        pl = 1'b0;
        await(1'b0, 1'b0, 100 * T);
        chk("recover", n >= 50 * T && n <= 52 * T + 8, 1'b1);
        for (int s = 0; s < 3; s++) begin
            write_sel(s[1:0]);
            chk("sel", st, s);
            kick_host();
            repeat (wdm[s] * T / 2) @(negedge clk);
            chk("wdo", wdo_n, 1'b1);
            kick_host();
            await(1'b1, 1'b1, (wdm[s] + 4) * T);
            chk("wdt", n >= wdm[s] * T && n <= (wdm[s] + 2) * T, 1'b1);
            chk("wdo", wdo_n, 1'b0);
            repeat (4 * T) @(negedge clk);
        end
        write_sel(2'h3);
        repeat (4) @(negedge clk);
        chk("off", woe, 1'b0);
        hit = 1'b0;
        for (int i = 0; i < 18 * T; i++) begin
            @(negedge clk);
            mr_n = ((i / (3 * T)) % 2) != 0;
            hit = hit | ro;
        end
        chk("bounce", hit, 1'b0);
        @(negedge clk) mr_n = 1'b0;
        repeat (40 * T) @(negedge clk);
        chk("manual", ro, 1'b1);
        mr_n = 1'b1;
        await(1'b0, 1'b0, 70 * T);
        chk("mrhold", n >= 60 * T && n <= 63 * T + 8, 1'b1);
        results();
    end
endmodule // dssw_top_tb
bind dssw_top dssw_monitor #(.RST_ACTIVE_HIGH(RST_ACTIVE_HIGH), .TICK_CYC(TICK_CYC)) mon (
    .clk(clk), .rst(rst), .primary_low(primary_low), .supply2_low(supply2_low),
    .primary_below_batt(primary_below_batt), .manual_reset_n(manual_reset_n),
    .scl_in(scl_in), .sda_in(sda_in), .wdt_sel_wr(wdt_sel_wr), .wdt_sel_wdata(wdt_sel_wdata),
    .system_reset_out(system_reset_out), .watchdog_out_n_oe(watchdog_out_n_oe),
    .early_low_supply_n_oe(early_low_supply_n_oe), .supply2_fail_n_oe(supply2_fail_n_oe),
    .backup_source_active(backup_source_active), .wdt_sel_store(wdt_sel_store));
